// ### design/wsr_consts.vh
/*
 * Offsets, fields, reset values, operation codes and limits of the shift unit.
 * Assumes it is included by its bare name from design and testbench files.
 */
`ifndef WSR_CONSTS_VH
`define WSR_CONSTS_VH

// ----------
// Register offsets (byte addresses)
// ----------
`define WSR_OFS_STATUS 8'h00
`define WSR_OFS_MASK 8'h04
`define WSR_OFS_FLAGS 8'h08
`define WSR_OFS_MEM_BASE 8'h40

// ----------
// Field positions
// ----------
`define WSR_EV_DONE 0
`define WSR_EV_ERROR 1
`define WSR_FL_CARRY 0
`define WSR_FL_EQUAL 1
`define WSR_FL_ERROR 2
`define WSR_FL_BUSY 3
`define WSR_CW_DIR 13
`define WSR_CW_ENABLE 14
`define WSR_CW_CLEAR 15

// ----------
// Reset values
// ----------
`define WSR_RST_STATUS 2'h0
`define WSR_RST_MASK 2'h0
`define WSR_RST_WORD 16'h0000

// ----------
// Operation codes
// ----------
`define WSR_OP_ROR 3'h0
`define WSR_OP_SLD 3'h1
`define WSR_OP_SRD 3'h2
`define WSR_OP_WSFT 3'h3
`define WSR_OP_RWS 3'h4
`define WSR_OP_STC 3'h5
`define WSR_OP_CLC 3'h6

// ----------
// Limits
// ----------
`define WSR_DM_LIMIT 14'h1387

`endif

// ### design/wsr_unit.v
/*
 * Word shift and rotate unit: rotate right through carry, digit shifts left and
 * right, whole word shift and reversible zero swap shift over a local word store.
 * Assumes one 250 MHz clock, operands already resolved by the instruction
 * sequencer, and a plain register port for software.
 */
// Summary of operation
// - Rotate right: carry enters bit 15, bit 00 becomes carry.
// - Condition false: operands and flags stay untouched.
// - Rotate right sets equal when the result is zero.
// - Bad indirect pointer, not BCD or past limit, raises error.
// - Digit left: range up four bits, zero in, top digit lost.
// - Digit left errors on area mismatch or start above end.
// - Digit right: range down four bits, zero into start's top digit.
// - Digit right errors on area mismatch or start below end.
// - Word shift moves words toward end; zero into start, end lost.
// - Each zero word swaps with its neighbour opposite the chosen direction.
// - No zero word present: an enabled run changes nothing.
// - A word that moves leaves zero behind.
// - Control bit 13 set moves words down; clear moves them up.
// - Control bit 14 clear disables shifting.
// - Control bit 15 zeroes the whole range instead of shifting.
// - Control bits 00 to 12 are ignored.
`include "wsr_consts.vh"
`default_nettype none

module wsr_unit #(
   parameter AW = 4,
   parameter DEPTH = 16,
   parameter [13:0] DM_LIMIT = `WSR_DM_LIMIT
) (
   // Clock and reset.
   input wire ref_clk_in,
   input wire sys_rst_in,
   // Operation issue from the sequencer.
   input wire op_start_in,
   input wire [2:0] op_code_in,
   input wire exec_cond_in,
   input wire [AW-1:0] start_addr_in,
   input wire [1:0] start_area_in,
   input wire [AW-1:0] end_addr_in,
   input wire [1:0] end_area_in,
   input wire [15:0] control_word_in,
   input wire indirect_in,
   input wire [15:0] pointer_in,
   output wire busy_out,
   output reg done_out,
   // Flags.
   output reg carry_flag_out,
   output reg equal_flag_out,
   output reg error_flag_out,
   // Register port.
   input wire [7:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [15:0] reg_rdata_out,
   // Interrupt.
   output wire irq_out
);

   // ----------
   // States
   // ----------
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   // ----------
   // Storage and control state
   // ----------
   reg [15:0] mem [0:DEPTH-1];
   reg [2:0] state;
   reg [2:0] op;
   reg [AW:0] cur;
   reg [AW:0] lo;
   reg [AW:0] hi;
   reg [3:0] nib;
   reg dir_down;
   reg clear_mode;
   reg [1:0] status;
   reg [1:0] mask;
   reg ev_done;
   reg ev_err;
   integer k;

   // ----------
   // Issue checks
   // ----------

   // Indirect pointer must be four BCD digits and within the data area.
   wire [3:0] pd3 = pointer_in[15:12];
   wire [3:0] pd2 = pointer_in[11:8];
   wire [3:0] pd1 = pointer_in[7:4];
   wire [3:0] pd0 = pointer_in[3:0];
   wire ptr_not_bcd = (pd3 > 4'h9) | (pd2 > 4'h9) | (pd1 > 4'h9) | (pd0 > 4'h9);
   wire [13:0] ptr_dec = pd3 * 14'h03E8 + pd2 * 14'h0064 + pd1 * 14'h000A + {10'h000, pd0};
   wire ptr_bad = indirect_in & (ptr_not_bcd | (ptr_dec > DM_LIMIT));

   wire area_bad = start_area_in != end_area_in;
   wire st_above = start_addr_in > end_addr_in;
   wire st_below = start_addr_in < end_addr_in;

   // Operand error per operation code.
   reg issue_err;
   always @* begin
      issue_err = ptr_bad;
      case (op_code_in)
         `WSR_OP_SLD: issue_err = ptr_bad | area_bad | st_above;
         `WSR_OP_SRD: issue_err = ptr_bad | area_bad | st_below;
         `WSR_OP_WSFT: issue_err = ptr_bad | area_bad | st_above;
         `WSR_OP_RWS: issue_err = ptr_bad | area_bad | st_above;
         default: issue_err = ptr_bad;
      endcase
   end

   // Rotate result, computed from the target word and the old carry.
   wire [15:0] tgt = mem[start_addr_in];
   wire [15:0] ror_res = {carry_flag_out, tgt[15:1]};

   // An issue is accepted only while idle.
   wire issue = op_start_in & (state == ST_IDLE);
   wire run_op = issue & exec_cond_in;

   // Range step helpers for the digit shifts, word shift and reversible register.
   wire [AW:0] cur_m1 = cur - {{AW{1'b0}}, 1'b1};
   wire [AW:0] cur_p1 = cur + {{AW{1'b0}}, 1'b1};
   wire [15:0] w_cur = mem[cur[AW-1:0]];
   wire [15:0] w_dn = mem[cur_m1[AW-1:0]];
   wire [15:0] w_up = mem[cur_p1[AW-1:0]];
   wire swap_up = (w_cur == 16'h0000) & (w_dn != 16'h0000);
   wire swap_dn = (w_cur == 16'h0000) & (w_up != 16'h0000);

   // Register port decode.
   wire mem_hit = (reg_addr_in >= `WSR_OFS_MEM_BASE) &
      (reg_addr_in < `WSR_OFS_MEM_BASE + DEPTH * 4) & (reg_addr_in[1:0] == 2'b00);
   wire [7:0] mem_off = reg_addr_in - `WSR_OFS_MEM_BASE;
   wire [AW-1:0] mem_idx = mem_off[AW+1:2];

   assign busy_out = state != ST_IDLE;
   assign irq_out = |(status & mask);

   // ----------
   // Sequencer, word store and flags
   // ----------

   // All word store writes live here so the array has a single driver. Software
   // writes to the store are dropped while an operation runs, which keeps the
   // range walk coherent at the cost of a silent refusal.
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         op <= `WSR_OP_ROR;
         cur <= {(AW+1){1'b0}};
         lo <= {(AW+1){1'b0}};
         hi <= {(AW+1){1'b0}};
         nib <= 4'h0;
         dir_down <= 1'b0;
         clear_mode <= 1'b0;
         carry_flag_out <= 1'b0;
         equal_flag_out <= 1'b0;
         error_flag_out <= 1'b0;
         done_out <= 1'b0;
         ev_done <= 1'b0;
         ev_err <= 1'b0;
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem[k] <= `WSR_RST_WORD;
         end
      end else begin
         done_out <= 1'b0;
         ev_done <= 1'b0;
         ev_err <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (reg_wr_in & mem_hit) begin
                  mem[mem_idx] <= reg_wdata_in;
               end
               if (issue & ~exec_cond_in) begin
                  state <= ST_DONE;
               end else if (run_op & issue_err) begin
                  error_flag_out <= 1'b1;
                  ev_err <= 1'b1;
                  state <= ST_DONE;
               end else if (run_op) begin
                  error_flag_out <= 1'b0;
                  op <= op_code_in;
                  case (op_code_in)
                     `WSR_OP_ROR: begin
                        mem[start_addr_in] <= ror_res;
                        carry_flag_out <= tgt[0];
                        equal_flag_out <= ror_res == 16'h0000;
                        state <= ST_DONE;
                     end
                     `WSR_OP_STC: begin
                        carry_flag_out <= 1'b1;
                        state <= ST_DONE;
                     end
                     `WSR_OP_CLC: begin
                        carry_flag_out <= 1'b0;
                        state <= ST_DONE;
                     end
                     `WSR_OP_SLD: begin
                        cur <= {1'b0, start_addr_in};
                        hi <= {1'b0, end_addr_in};
                        nib <= 4'h0;
                        state <= ST_RUN;
                     end
                     `WSR_OP_SRD: begin
                        cur <= {1'b0, start_addr_in};
                        lo <= {1'b0, end_addr_in};
                        nib <= 4'h0;
                        state <= ST_RUN;
                     end
                     `WSR_OP_WSFT: begin
                        cur <= {1'b0, end_addr_in};
                        lo <= {1'b0, start_addr_in};
                        state <= ST_RUN;
                     end
                     `WSR_OP_RWS: begin
                        // Only bits 13 to 15 are looked at.
                        dir_down <= control_word_in[`WSR_CW_DIR];
                        clear_mode <= control_word_in[`WSR_CW_CLEAR];
                        lo <= {1'b0, start_addr_in};
                        hi <= {1'b0, end_addr_in};
                        if (control_word_in[`WSR_CW_CLEAR]) begin
                           cur <= {1'b0, start_addr_in};
                           state <= ST_RUN;
                        end else if (~control_word_in[`WSR_CW_ENABLE]) begin
                           state <= ST_DONE;
                        end else if (control_word_in[`WSR_CW_DIR]) begin
                           cur <= {1'b0, start_addr_in};
                           state <= ST_RUN;
                        end else begin
                           cur <= {1'b0, end_addr_in};
                           state <= ST_RUN;
                        end
                     end
                     default: begin
                        state <= ST_DONE;
                     end
                  endcase
               end
            end
            ST_RUN: begin
               case (op)
                  `WSR_OP_SLD: begin
                     // Walks upward one word a cycle, carrying the top digit.
                     mem[cur[AW-1:0]] <= {w_cur[11:0], nib};
                     nib <= w_cur[15:12];
                     cur <= cur_p1;
                     if (cur == hi) begin
                        state <= ST_DONE;
                     end
                  end
                  `WSR_OP_SRD: begin
                     // Walks downward from the start word toward the end word.
                     mem[cur[AW-1:0]] <= {nib, w_cur[15:4]};
                     nib <= w_cur[3:0];
                     cur <= cur_m1;
                     if (cur == lo) begin
                        state <= ST_DONE;
                     end
                  end
                  `WSR_OP_WSFT: begin
                     // Top down so each word is read before it is overwritten.
                     if (cur == lo) begin
                        mem[cur[AW-1:0]] <= 16'h0000;
                        state <= ST_DONE;
                     end else begin
                        mem[cur[AW-1:0]] <= w_dn;
                        cur <= cur_m1;
                     end
                  end
                  `WSR_OP_RWS: begin
                     if (clear_mode) begin
                        mem[cur[AW-1:0]] <= 16'h0000;
                        cur <= cur_p1;
                        if (cur == hi) begin
                           state <= ST_DONE;
                        end
                     end else if (~dir_down) begin
                        // Upward: a zero word takes the word just below it.
                        if (cur == lo) begin
                           state <= ST_DONE;
                        end else if (swap_up) begin
                           mem[cur[AW-1:0]] <= w_dn;
                           mem[cur_m1[AW-1:0]] <= 16'h0000;
                           // Skip the vacated word so a word moves one place only.
                           if (cur_m1 == lo) begin
                              state <= ST_DONE;
                           end else begin
                              cur <= cur - {{(AW-1){1'b0}}, 2'b10};
                           end
                        end else begin
                           cur <= cur_m1;
                        end
                     end else begin
                        // Downward: a zero word takes the word just above it.
                        if (cur == hi) begin
                           state <= ST_DONE;
                        end else if (swap_dn) begin
                           mem[cur[AW-1:0]] <= w_up;
                           mem[cur_p1[AW-1:0]] <= 16'h0000;
                           if (cur_p1 == hi) begin
                              state <= ST_DONE;
                           end else begin
                              cur <= cur + {{(AW-1){1'b0}}, 2'b10};
                           end
                        end else begin
                           cur <= cur_p1;
                        end
                     end
                  end
                  default: begin
                     state <= ST_DONE;
                  end
               endcase
            end
            ST_DONE: begin
               done_out <= 1'b1;
               ev_done <= 1'b1;
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------
   // Event status and mask
   // ----------

   // Sticky events; a new event in the clearing cycle wins over the clear.
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status <= `WSR_RST_STATUS;
         mask <= `WSR_RST_MASK;
      end else begin
         if (reg_wr_in & (reg_addr_in == `WSR_OFS_STATUS)) begin
            status <= (status & ~reg_wdata_in[1:0]) | {ev_err, ev_done};
         end else begin
            status <= status | {ev_err, ev_done};
         end
         if (reg_wr_in & (reg_addr_in == `WSR_OFS_MASK)) begin
            mask <= reg_wdata_in[1:0];
         end
      end
   end

   // ----------
   // Read data
   // ----------

   // Read data stands for one cycle only; unmapped offsets read as zero.
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in) begin
         if (reg_addr_in == `WSR_OFS_STATUS) begin
            reg_rdata_out <= {14'h0000, status};
         end else if (reg_addr_in == `WSR_OFS_MASK) begin
            reg_rdata_out <= {14'h0000, mask};
         end else if (reg_addr_in == `WSR_OFS_FLAGS) begin
            reg_rdata_out <= {12'h000, busy_out, error_flag_out, equal_flag_out,
               carry_flag_out};
         end else if (mem_hit) begin
            reg_rdata_out <= mem[mem_idx];
         end else begin
            reg_rdata_out <= 16'h0000;
         end
      end else begin
         reg_rdata_out <= 16'h0000;
      end
   end

endmodule // wsr_unit

`default_nettype wire

// ### tb/wsr_monitor.sv
/* Checker for the word shift and rotate unit: timing and flag relations at the
   sequencer port. Assumes it is bound to the unit and sees only its ports. */
`include "wsr_consts.vh"
`default_nettype none
module wsr_monitor #(
   parameter AW = 4,
   parameter [13:0] DM_LIMIT = `WSR_DM_LIMIT
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Sequencer port.
   input wire logic op_start_in,
   input wire logic [2:0] op_code_in,
   input wire logic exec_cond_in,
   input wire logic [AW-1:0] start_addr_in,
   input wire logic [1:0] start_area_in,
   input wire logic [AW-1:0] end_addr_in,
   input wire logic [1:0] end_area_in,
   input wire logic [15:0] control_word_in,
   input wire logic indirect_in,
   input wire logic [15:0] pointer_in,
   // Handshake and flags.
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic carry_flag_out,
   input wire logic equal_flag_out,
   input wire logic error_flag_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // Helpers
   // ----------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   // A pointer must be four BCD digits no larger than the area limit.
   function automatic logic bad_ptr(input logic [15:0] p);
      int v;
      v = p[15:12] * 1000 + p[11:8] * 100 + p[7:4] * 10 + p[3:0];
      return p[15:12] > 9 || p[11:8] > 9 || p[7:4] > 9 || p[3:0] > 9 || v > DM_LIMIT;
   endfunction

   // A request while busy is dropped, so only accepted issues count.
   wire take = op_start_in & ~busy_out;
   wire go = take & exec_cond_in;
   wire area_ne = start_area_in != end_area_in;
   wire l_bad = op_code_in == `WSR_OP_SLD && (area_ne || start_addr_in > end_addr_in);
   wire r_bad = op_code_in == `WSR_OP_SRD && (area_ne || start_addr_in < end_addr_in);
   wire [2:0] flg = {carry_flag_out, equal_flag_out, error_flag_out};

   // ----------
   // Assertions
   // ----------
   rot_timing_a:
      assert property (go && op_code_in == `WSR_OP_ROR |=> busy_out ##1 done_out)
      else $error("rotate did not complete in two cycles");
   cond_false_a:
      assert property (take && !exec_cond_in |=> $stable(flg) ##1 ($stable(flg) && done_out))
      else $error("flags moved on a skipped operation");
   eq_hold_a:
      assert property (go && op_code_in != `WSR_OP_ROR |=> $stable(equal_flag_out) [*2])
      else $error("equal flag changed by a non-rotate operation");
   ptr_err_a:
      assert property (go && indirect_in && bad_ptr(pointer_in) |-> ##[1:2] error_flag_out)
      else $error("bad pointer did not raise the error flag");
   carry_op_a:
      assert property (go && !indirect_in && op_code_in inside {`WSR_OP_STC, `WSR_OP_CLC}
         |=> !error_flag_out && carry_flag_out == ($past(op_code_in) == `WSR_OP_STC))
      else $error("carry operation gave wrong carry or error");
   left_err_a:
      assert property (go && l_bad |-> ##[1:2] error_flag_out)
      else $error("digit left range fault not flagged");
   right_err_a:
      assert property (go && r_bad |-> ##[1:2] error_flag_out)
      else $error("digit right range fault not flagged");
   err_carry_a:
      assert property (go && (l_bad || r_bad) |=> $stable(carry_flag_out) [*2])
      else $error("carry changed on an operand error");
   rws_off_a:
      assert property (go && op_code_in == `WSR_OP_RWS && control_word_in[15:14] == 2'b00
         |=> busy_out ##1 done_out)
      else $error("disabled reversible shift did not finish at once");
endmodule // wsr_monitor
`default_nettype wire

// ### tb/wsr_seq_model.sv
/* Instruction sequencer model: issues one operation at a time and waits for the
   done pulse. Assumes the unit's busy and done handshake on one clock. */
`include "wsr_consts.vh"
`default_nettype none
module wsr_seq_model (
   // Clock and handshake.
   input wire logic clk_in,
   input wire logic busy_in,
   input wire logic done_in,
   // Operation fields.
   output logic start_out,
   output logic [2:0] code_out,
   output logic cond_out,
   output logic [3:0] sa_out,
   output logic [1:0] sar_out,
   output logic [3:0] ea_out,
   output logic [1:0] ear_out,
   output logic [15:0] cw_out,
   output logic ind_out,
   output logic [15:0] ptr_out,
   // Set when a done pulse never came.
   output logic stall_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {start_out, code_out, cond_out, sa_out, sar_out, ea_out, ear_out} = '0;
   initial {cw_out, ind_out, ptr_out, stall_out} = '0;

   // Fields are held after the strobe, so the unit may sample them late.
   task automatic run(input logic [2:0] c, input logic e, input logic [3:0] s,
                      input logic [1:0] sr, input logic [3:0] en, input logic [1:0] er,
                      input logic [15:0] w, input logic i, input logic [15:0] p);
      int n;
      n = 0;
      while (busy_in === 1'h1 && n < 64) begin
         @(negedge clk_in);
         n++;
      end
      @(posedge clk_in);
      start_out <= 1'h1;
      {code_out, cond_out, sa_out, sar_out, ea_out, ear_out} <= {c, e, s, sr, en, er};
      {cw_out, ind_out, ptr_out} <= {w, i, p};
      @(posedge clk_in);
      start_out <= 1'h0;
      while (done_in !== 1'h1 && n < 64) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 64) stall_out = 1'h1;
   endtask

   // Carry is set or cleared first, so the bit rotated in is known.
   task automatic rot(input logic cy, input logic [3:0] a, input logic e, input logic i,
                      input logic [15:0] p);
      run(cy ? `WSR_OP_STC : `WSR_OP_CLC, 1'h1, a, 2'h0, a, 2'h0, 16'h0000, 1'h0, 16'h0000);
      run(`WSR_OP_ROR, e, a, 2'h0, a, 2'h0, 16'h0000, i, p);
   endtask

   // Range operations as the caller gives them; only error cases break area order.
   task automatic rng(input logic [2:0] c, input logic [3:0] s, input logic [1:0] sr,
                      input logic [3:0] en, input logic [1:0] er, input logic [15:0] w);
      run(c, 1'h1, s, sr, en, er, w, 1'h0, 16'h0000);
   endtask
endmodule // wsr_seq_model
`default_nettype wire

// ### tb/testbench.sv
/* Testbench for the word shift and rotate unit: register tasks, a sequencer
   model and directed operation sequences. Assumes the design include path. */
`include "wsr_consts.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // Signals and instances
   // ----------
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] ra = 8'h00;
   logic [15:0] rwd = 16'h0000;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [15:0] rdat, cw, ptr, v;
   logic [3:0] sa, ea;
   logic [2:0] code;
   logic [1:0] sar, ear;
   logic st, cond, ind, busy, done, cy, eq, er, irq, stall;
   int error_cnt = 0;
   int n_compared = 0;
   logic [15:0] bf[11] = '{16'h1234, 16'h0000, 16'h0000, 16'h2345, 16'h3456, 16'h0000,
                           16'h4567, 16'h5678, 16'h6789, 16'h0000, 16'h789A};
   logic [15:0] af[11] = '{16'h0000, 16'h1234, 16'h0000, 16'h2345, 16'h0000, 16'h3456,
                           16'h4567, 16'h5678, 16'h0000, 16'h6789, 16'h789A};

   always #2 clk = ~clk;

   wsr_unit #(.AW(4), .DEPTH(16)) DUT (
      .ref_clk_in(clk), .sys_rst_in(rst), .op_start_in(st), .op_code_in(code),
      .exec_cond_in(cond), .start_addr_in(sa), .start_area_in(sar), .end_addr_in(ea),
      .end_area_in(ear), .control_word_in(cw), .indirect_in(ind), .pointer_in(ptr),
      .busy_out(busy), .done_out(done), .carry_flag_out(cy), .equal_flag_out(eq),
      .error_flag_out(er), .reg_addr_in(ra), .reg_wdata_in(rwd), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdat), .irq_out(irq));

   wsr_seq_model sq (
      .clk_in(clk), .busy_in(busy), .done_in(done), .start_out(st), .code_out(code),
      .cond_out(cond), .sa_out(sa), .sar_out(sar), .ea_out(ea), .ear_out(ear),
      .cw_out(cw), .ind_out(ind), .ptr_out(ptr), .stall_out(stall));

   // ----------
   // Tasks
   // ----------
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Sampling at the falling edge keeps reads clear of the launching edge.
   task automatic rwr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      {ra, rwd, wr} <= {a, d, 1'h1};
      @(posedge clk);
      wr <= 1'h0;
      @(negedge clk);
   endtask
   task automatic rrd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      {ra, rd} <= {a, 1'h1};
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      d = rdat;
   endtask
   task automatic ww(input int i, input logic [15:0] d);
      rwr(8'(`WSR_OFS_MEM_BASE + 4 * i), d);
   endtask
   task automatic cwd(input int i, input logic [15:0] e);
      logic [15:0] x;
      rrd(8'(`WSR_OFS_MEM_BASE + 4 * i), x);
      chk("word", x, e);
   endtask
   task automatic cw3(input int i, input logic [15:0] a, b, c);
      cwd(i, a);
      cwd(i + 1, b);
      cwd(i + 2, c);
   endtask
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------
   // Sequences
   // ----------
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      rrd(`WSR_OFS_MASK, v);
      chk("mask", v, 16'h0000);
      ww(0, 16'h0003);
      sq.rot(1'h0, 4'h0, 1'h1, 1'h0, 16'h0000);
      cwd(0, 16'h0001);
      chk("carry", cy, 1'h1);
      chk("equal", eq, 1'h0);
      sq.rot(1'h1, 4'h0, 1'h1, 1'h0, 16'h0000);
      cwd(0, 16'h8000);
      ww(1, 16'h0001);
      sq.rot(1'h0, 4'h1, 1'h1, 1'h0, 16'h0000);
      rrd(`WSR_OFS_FLAGS, v);
      chk("flags", v, 16'h0003);
      sq.rot(1'h0, 4'h0, 1'h0, 1'h0, 16'h0000);
      cwd(0, 16'h8000);
      chk("equal", eq, 1'h1);
      // Bad digit, then past the limit, then the limit itself.
      sq.rot(1'h1, 4'h0, 1'h1, 1'h1, 16'h12A4);
      chk("error", er, 1'h1);
      chk("carry", cy, 1'h1);
      sq.rot(1'h0, 4'h0, 1'h1, 1'h1, 16'h5000);
      chk("error", er, 1'h1);
      cwd(0, 16'h8000);
      sq.rot(1'h0, 4'h0, 1'h1, 1'h1, 16'h4999);
      cwd(0, 16'h4000);
      ww(2, 16'h1234);
      ww(3, 16'h5678);
      ww(4, 16'h9ABC);
      sq.rng(`WSR_OP_SLD, 4'h2, 2'h0, 4'h4, 2'h0, 16'h0000);
      cw3(2, 16'h2340, 16'h6781, 16'hABC5);
      sq.rng(`WSR_OP_SRD, 4'h4, 2'h0, 4'h2, 2'h0, 16'h0000);
      cw3(2, 16'h1234, 16'h5678, 16'h0ABC);
      sq.rng(`WSR_OP_SLD, 4'h4, 2'h0, 4'h2, 2'h0, 16'h0000);
      chk("error", er, 1'h1);
      sq.rng(`WSR_OP_SLD, 4'h2, 2'h0, 4'h4, 2'h1, 16'h0000);
      chk("error", er, 1'h1);
      sq.rng(`WSR_OP_SRD, 4'h2, 2'h0, 4'h4, 2'h0, 16'h0000);
      chk("error", er, 1'h1);
      sq.rng(`WSR_OP_SRD, 4'h4, 2'h1, 4'h2, 2'h0, 16'h0000);
      cw3(2, 16'h1234, 16'h5678, 16'h0ABC);
      sq.rng(`WSR_OP_WSFT, 4'h2, 2'h0, 4'h4, 2'h0, 16'h0000);
      cw3(2, 16'h0000, 16'h1234, 16'h5678);
      sq.rng(`WSR_OP_WSFT, 4'h4, 2'h0, 4'h2, 2'h0, 16'h0000);
      cw3(2, 16'h0000, 16'h1234, 16'h5678);
      for (int k = 0; k < 11; k++) ww(k, bf[k]);
      sq.rng(`WSR_OP_RWS, 4'h0, 2'h0, 4'hA, 2'h0, 16'h4000);
      for (int k = 0; k < 11; k++) cwd(k, af[k]);
      ww(11, 16'h1111);
      ww(12, 16'h0000);
      ww(13, 16'h2222);
      sq.rng(`WSR_OP_RWS, 4'hB, 2'h0, 4'hD, 2'h0, 16'h7FFF);
      cw3(11, 16'h1111, 16'h2222, 16'h0000);
      sq.rng(`WSR_OP_RWS, 4'hB, 2'h0, 4'hD, 2'h0, 16'h2000);
      cw3(11, 16'h1111, 16'h2222, 16'h0000);
      ww(13, 16'h3333);
      sq.rng(`WSR_OP_RWS, 4'hB, 2'h0, 4'hD, 2'h0, 16'h4000);
      cw3(11, 16'h1111, 16'h2222, 16'h3333);
      sq.rng(`WSR_OP_RWS, 4'hD, 2'h0, 4'hB, 2'h0, 16'h4000);
      chk("error", er, 1'h1);
      sq.rng(`WSR_OP_RWS, 4'hB, 2'h0, 4'hD, 2'h0, 16'hC000);
      cw3(10, 16'h789A, 16'h0000, 16'h0000);
      // Status holds both events; the mask gates the interrupt line.
      rrd(`WSR_OFS_STATUS, v);
      chk("status", v, 16'h0003);
      chk("irq", irq, 1'h0);
      rwr(`WSR_OFS_MASK, 16'h0002);
      chk("irq", irq, 1'h1);
      rwr(`WSR_OFS_STATUS, 16'h0002);
      chk("irq", irq, 1'h0);
      rrd(`WSR_OFS_STATUS, v);
      chk("status", v, 16'h0001);
      rrd(8'h20, v);
      chk("unmapped", v, 16'h0000);
      chk("stall", stall, 1'h0);
      conclude();
   end

   // The sequences need a few hundred cycles; this cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
endmodule // testbench

bind wsr_unit wsr_monitor #(.AW(AW), .DM_LIMIT(DM_LIMIT)) mon (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .op_start_in(op_start_in),
   .op_code_in(op_code_in), .exec_cond_in(exec_cond_in), .start_addr_in(start_addr_in),
   .start_area_in(start_area_in), .end_addr_in(end_addr_in), .end_area_in(end_area_in),
   .control_word_in(control_word_in), .indirect_in(indirect_in), .pointer_in(pointer_in),
   .busy_out(busy_out), .done_out(done_out), .carry_flag_out(carry_flag_out),
   .equal_flag_out(equal_flag_out), .error_flag_out(error_flag_out));
`default_nettype wire
